// *** rtl/gcsg_top.sv ***
`timescale 1ns/100ps

// Functional notes
// RL1 - each global network has one control block on one periphery side.
// RL2 - small parts carry 8 blocks, large parts 16, one clock each.
// RL3 - sources are clock pins, counter outputs, dual-purpose pins, fabric logic.
// RL4 - a dedicated clock input may carry a clock or a global control.
// RL5 - block offers run-time source selection and run-time network gating.
// RL6 - a two-bit fabric select picks the network source in user mode.
// RL7 - static selection comes from configuration and is locked in user mode.
// RL8 - fabric logic enables or disables the network through the enable input.
// RL9 - a two-input mux feeds the pll reference, static or manually switched.
// RL10 - of three counter outputs only two are offered to the network.
// RL11 - each side pools pins, counters, dual-purpose pins and fabric signals.
// RL12 - every block takes exactly six inputs.
// RL13 - only the two clock pins and two counter outputs are dynamic.
// RL14 - dual-purpose pin and fabric signal are selectable statically only.
// RL15 - a disabled network delivers no edges to its loads.
// RL16 - unused networks are powered down by a configuration bit.
// RL17 - enable acts on the network itself, with or without a pll.
// RL18 - re-enabling gives edges at once, no relock interval.
// RL19 - gating never touches pll counters; the pll stays locked.
// RL20 - enable is sampled on the falling edge of the selected clock.
// RL21 - fabric may drop enable during pll resynchronisation overshoot.
// RL22 - fabric drops enable, changes select, waits, then raises enable.
// RL23 - select values map one-to-one onto the four dynamic sources.
// RL24 - falling-edge enable plus and gate never truncates a high pulse.
module gcsg_top
    import gcsg_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire gcsg_pkg::gcsg_axi_req_t axi_req,
    output      gcsg_pkg::gcsg_axi_rsp_t axi_rsp,
    input  wire logic [1:0]              dedicated_clock_pin,
    input  wire logic [1:0]              pll_counter_output,
    input  wire logic                    dual_purpose_clock_pin,
    input  wire logic                    fabric_logic_element_signal,
    input  wire logic [1:0]              network_source_select,
    input  wire logic                    network_enable,
    input  wire logic                    pll_reference_switch,
    output      logic                    network_clock,
    output      logic                    pll_reference_clock
);
    import gcsg_pkg::*;

    // ****************************************************************
    // declarations
    // ****************************************************************
    // bus write side
    logic        aw_held_q;
    logic [31:0] awaddr_q;
    logic        w_held_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        aw_fire;
    logic        w_fire;
    logic        wr_commit;
    gcsg_reg_t   wr_reg;

    // bus read side
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic        ar_fire;
    gcsg_reg_t   rd_reg;

    // registers
    logic [31:0] cfg_q;
    logic [31:0] cfg_d;
    logic [31:0] stat_word;

    // synchronisers for fabric levels and gate state
    logic [1:0]  sel_meta_q;
    logic [1:0]  sel_q;
    logic        en_meta_q;
    logic        en_sync_q;
    logic        sw_meta_q;
    logic        sw_q;
    logic        gate_meta_q;
    logic        gate_q;

    // clock path
    logic        selected_clock;
    logic        gate_enable;
    logic        gate_state;
    logic        ref_sel;

    // ****************************************************************
    // byte-lane merge
    // ****************************************************************
    function automatic logic [31:0] merge_bytes(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  strb
    );
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b = b + 1) begin
            if (strb[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // ****************************************************************
    // write address and data channels
    // ****************************************************************
    // one write outstanding; channels accepted in either order
    assign aw_fire   = axi_req.awvalid & ~aw_held_q & ~bvalid_q;
    assign w_fire    = axi_req.wvalid & ~w_held_q & ~bvalid_q;
    assign wr_commit = aw_held_q & w_held_q;
    assign wr_reg    = gcsg_decode(awaddr_q);

    // address hold
    always_ff @(posedge clk) begin
        if (rst) begin
            aw_held_q <= 1'b0;
            awaddr_q  <= 32'h0000_0000;
        end else if (aw_fire) begin
            aw_held_q <= 1'b1;
            awaddr_q  <= axi_req.awaddr;
        end else if (wr_commit) begin
            aw_held_q <= 1'b0;
        end
    end

    // data hold
    always_ff @(posedge clk) begin
        if (rst) begin
            w_held_q <= 1'b0;
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
        end else if (w_fire) begin
            w_held_q <= 1'b1;
            wdata_q  <= axi_req.wdata;
            wstrb_q  <= axi_req.wstrb;
        end else if (wr_commit) begin
            w_held_q <= 1'b0;
        end
    end

    // ****************************************************************
    // write response
    // ****************************************************************
    // locked or unmapped writes are dropped and answered with an error
    always_ff @(posedge clk) begin
        if (rst) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (wr_commit) begin
            bvalid_q <= 1'b1;
            if (wr_reg == REG_CFG && !cfg_q[CFG_LOCK_BIT]) begin
                bresp_q <= RESP_OKAY;
            end else begin
                bresp_q <= RESP_SLVERR;
            end
        end else if (bvalid_q && axi_req.bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ****************************************************************
    // configuration register
    // ****************************************************************
    // lock bit sticks until system reset, standing in for user mode entry
    always_comb begin
        cfg_d = cfg_q;
        if (wr_commit && wr_reg == REG_CFG && !cfg_q[CFG_LOCK_BIT]) begin // [RL7]
            cfg_d = merge_bytes(cfg_q, wdata_q, wstrb_q) & CFG_WMASK;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_q <= CFG_RESET;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    // ****************************************************************
    // status word
    // ****************************************************************
    // block count reflects the family size chosen in configuration
    always_comb begin
        stat_word = 32'h0000_0000;
        stat_word[STAT_SEL_LSB +: 2] = sel_q;
        stat_word[STAT_EN_BIT]       = gate_q;
        stat_word[STAT_LOCK_BIT]     = cfg_q[CFG_LOCK_BIT];
        stat_word[STAT_DYN_BIT]      =
            (gcsg_static_kind(cfg_q[CFG_STATIC_LSB +: 2]) == SRC_DYNAMIC); // [RL5]
        stat_word[STAT_CNT_LSB +: 5] =
            cfg_q[CFG_LARGE_BIT] ? BLOCKS_LARGE : BLOCKS_SMALL; // [RL2] [RL1]
    end

    // ****************************************************************
    // read channel
    // ****************************************************************
    assign ar_fire = axi_req.arvalid & ~rvalid_q;
    assign rd_reg  = gcsg_decode(axi_req.araddr);

    // data captured at acceptance, held until the master takes it
    always_ff @(posedge clk) begin
        if (rst) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= RESP_OKAY;
        end else if (ar_fire) begin
            rvalid_q <= 1'b1;
            case (rd_reg)
                REG_CFG: begin
                    rdata_q <= cfg_q;
                    rresp_q <= RESP_OKAY;
                end
                REG_STAT: begin
                    rdata_q <= stat_word;
                    rresp_q <= RESP_OKAY;
                end
                default: begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && axi_req.rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ****************************************************************
    // bus outputs
    // ****************************************************************
    always_comb begin
        axi_rsp         = '0;
        axi_rsp.awready = ~aw_held_q & ~bvalid_q;
        axi_rsp.wready  = ~w_held_q & ~bvalid_q;
        axi_rsp.bvalid  = bvalid_q;
        axi_rsp.bresp   = bresp_q;
        axi_rsp.arready = ~rvalid_q;
        axi_rsp.rvalid  = rvalid_q;
        axi_rsp.rdata   = rdata_q;
        axi_rsp.rresp   = rresp_q;
    end

    // ****************************************************************
    // fabric level and gate state synchronisers
    // ****************************************************************
    // select is retimed, so a change lands two clk edges later; fabric
    // should hold the network disabled across that window [RL22]
    always_ff @(posedge clk) begin
        if (rst) begin
            sel_meta_q <= SEL_CLK_PIN0;
            sel_q      <= SEL_CLK_PIN0;
        end else begin
            sel_meta_q <= network_source_select;
            sel_q      <= sel_meta_q; // [RL6]
        end
    end

    // enable held low through reset so the network starts gated
    always_ff @(posedge clk) begin
        if (rst) begin
            en_meta_q <= 1'b0;
            en_sync_q <= 1'b0;
        end else begin
            en_meta_q <= network_enable;
            en_sync_q <= en_meta_q; // [RL8] [RL21]
        end
    end

    // manual reference switchover request
    always_ff @(posedge clk) begin
        if (rst) begin
            sw_meta_q <= 1'b0;
            sw_q      <= 1'b0;
        end else begin
            sw_meta_q <= pll_reference_switch;
            sw_q      <= sw_meta_q;
        end
    end

    // gate state back from the selected clock; stale if that clock stops
    always_ff @(posedge clk) begin
        if (rst) begin
            gate_meta_q <= 1'b0;
            gate_q      <= 1'b0;
        end else begin
            gate_meta_q <= gate_state;
            gate_q      <= gate_meta_q;
        end
    end

    // ****************************************************************
    // source selection
    // ****************************************************************
    // third counter output is not wired into this block at all [RL10]
    gcsg_src_mux u_src_mux (
        .clock_pin                   (dedicated_clock_pin), // [RL4] [RL11]
        .pll_out                     (pll_counter_output),
        .dual_purpose_clock_pin      (dual_purpose_clock_pin),
        .fabric_logic_element_signal (fabric_logic_element_signal),
        .dyn_sel                     (sel_q),
        .static_field                (cfg_q[CFG_STATIC_LSB +: 2]),
        .clk_out                     (selected_clock)
    );

    // ****************************************************************
    // network gate
    // ****************************************************************
    // unused networks stay off whatever fabric asks for
    assign gate_enable = en_sync_q & cfg_q[CFG_USED_BIT]; // [RL16] [RL15]

    gcsg_clk_gate u_clk_gate (
        .clk_in   (selected_clock),
        .en_in    (gate_enable),
        .clk_out  (network_clock),
        .en_state (gate_state)
    );

    // ****************************************************************
    // pll reference mux
    // ****************************************************************
    // independent of the gate, so gating leaves the loop undisturbed
    assign ref_sel = cfg_q[CFG_MANSW_BIT] ? sw_q : cfg_q[CFG_REFSEL_BIT]; // [RL9]

    assign pll_reference_clock = ref_sel ? dedicated_clock_pin[1]
                                         : dedicated_clock_pin[0]; // [RL19]

endmodule

// *** rtl/gcsg_pkg.sv ***
package gcsg_pkg;

    // ****************************************************************
    // register map, byte addresses on the 32-bit bus
    // ****************************************************************
    localparam logic [7:0]  CFG_OFS         = 8'h00;
    localparam logic [7:0]  STAT_OFS        = 8'h04;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    // configuration word fields
    localparam int          CFG_STATIC_LSB  = 0;
    localparam int          CFG_REFSEL_BIT  = 2;
    localparam int          CFG_MANSW_BIT   = 3;
    localparam int          CFG_USED_BIT    = 4;
    localparam int          CFG_LOCK_BIT    = 5;
    localparam int          CFG_SIDE_LSB    = 6;
    localparam int          CFG_LARGE_BIT   = 8;
    localparam logic [31:0] CFG_RESET       = 32'h0000_0010;
    localparam logic [31:0] CFG_WMASK       = 32'h0000_01ff;

    // status word fields
    localparam int          STAT_SEL_LSB    = 0;
    localparam int          STAT_EN_BIT     = 2;
    localparam int          STAT_LOCK_BIT   = 3;
    localparam int          STAT_DYN_BIT    = 4;
    localparam int          STAT_CNT_LSB    = 16;

    // ****************************************************************
    // device organisation
    // ****************************************************************
    localparam logic [4:0]  BLOCKS_SMALL    = 5'h08;
    localparam logic [4:0]  BLOCKS_LARGE    = 5'h10;
    localparam int          DYN_INPUTS      = 4;

    // dynamic select encoding
    localparam logic [1:0]  SEL_CLK_PIN0    = 2'h0;
    localparam logic [1:0]  SEL_CLK_PIN1    = 2'h1;
    localparam logic [1:0]  SEL_PLL_OUT0    = 2'h2;
    localparam logic [1:0]  SEL_PLL_OUT1    = 2'h3;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [1:0] {
        SRC_DYNAMIC,
        SRC_DUAL_PURPOSE,
        SRC_INTERNAL
    } gcsg_src_kind_t;

    typedef enum logic [1:0] {
        REG_CFG,
        REG_STAT,
        REG_NONE
    } gcsg_reg_t;

    typedef struct packed {
        logic [31:0] awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [31:0] araddr;
        logic        arvalid;
        logic        rready;
    } gcsg_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic [1:0]  bresp;
        logic        bvalid;
        logic        arready;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        rvalid;
    } gcsg_axi_rsp_t;

    // static source field to kind; the unused code falls back to dynamic
    function automatic gcsg_src_kind_t gcsg_static_kind(input logic [1:0] f);
        gcsg_src_kind_t k;
        k = SRC_DYNAMIC;
        case (f)
            2'h1:    k = SRC_DUAL_PURPOSE;
            2'h2:    k = SRC_INTERNAL;
            default: k = SRC_DYNAMIC;
        endcase
        return k;
    endfunction

    // address decode, low two bits ignored
    function automatic gcsg_reg_t gcsg_decode(input logic [31:0] a);
        gcsg_reg_t r;
        r = REG_NONE;
        if (a[31:8] == 24'h00_0000) begin
            if (a[7:2] == CFG_OFS[7:2]) begin
                r = REG_CFG;
            end else if (a[7:2] == STAT_OFS[7:2]) begin
                r = REG_STAT;
            end
        end
        return r;
    endfunction

endpackage

// *** rtl/gcsg_src_mux.sv ***
`timescale 1ns/100ps

module gcsg_src_mux
    import gcsg_pkg::*;
(
    input  wire logic [1:0] clock_pin,
    input  wire logic [1:0] pll_out,
    input  wire logic       dual_purpose_clock_pin,
    input  wire logic       fabric_logic_element_signal,
    input  wire logic [1:0] dyn_sel,
    input  wire logic [1:0] static_field,
    output      logic       clk_out
);

    // ****************************************************************
    // dynamic four-way selection
    // ****************************************************************
    logic [DYN_INPUTS-1:0] dyn_src;
    logic [DYN_INPUTS-1:0] dyn_term;
    logic                  dyn_clk;

    // clock pins first, then the two offered counter outputs
    assign dyn_src = {pll_out[1], pll_out[0], clock_pin[1], clock_pin[0]}; // [RL23] [RL12]

    // and-or tree, one term per candidate
    genvar i;
    generate
        for (i = 0; i < DYN_INPUTS; i = i + 1) begin : g_term
            assign dyn_term[i] = dyn_src[i] & (dyn_sel == 2'(i)); // [RL6] [RL13]
        end
    endgenerate

    assign dyn_clk = |dyn_term;

    // ****************************************************************
    // static override from configuration
    // ****************************************************************
    // dual-purpose pin and fabric signal never reach the dynamic path
    always_comb begin
        case (gcsg_static_kind(static_field))
            SRC_DUAL_PURPOSE: clk_out = dual_purpose_clock_pin; // [RL14]
            SRC_INTERNAL:     clk_out = fabric_logic_element_signal; // [RL14]
            default:          clk_out = dyn_clk; // [RL3]
        endcase
    end

endmodule

// *** rtl/gcsg_clk_gate.sv ***
`timescale 1ns/100ps

module gcsg_clk_gate (
    input  wire logic clk_in,
    input  wire logic en_in,
    output      logic clk_out,
    output      logic en_state
);

    // ****************************************************************
    // falling-edge enable sampling
    // ****************************************************************
    logic en_meta_q;
    logic en_q;

    // two stages on the falling edge; no reset, since the source clock may
    // be stopped while the system reset is applied
    always_ff @(negedge clk_in) begin
        en_meta_q <= en_in; // [RL20]
        en_q      <= en_meta_q; // [RL17]
    end

    // ****************************************************************
    // gate
    // ****************************************************************
    // enable only changes while the clock is low, so no high pulse is cut
    assign clk_out  = clk_in & en_q; // [RL24] [RL15] [RL18]
    assign en_state = en_q;

endmodule

// *** tb/gcsg_top_checker.sv ***
`timescale 1ns/100ps

module gcsg_top_checker
    import gcsg_pkg::*;
(
    input wire logic                    clk,
    input wire logic                    rst,
    input wire gcsg_pkg::gcsg_axi_req_t axi_req,
    input wire gcsg_pkg::gcsg_axi_rsp_t axi_rsp,
    input wire logic [1:0]              dedicated_clock_pin,
    input wire logic [1:0]              pll_counter_output,
    input wire logic                    dual_purpose_clock_pin,
    input wire logic                    fabric_logic_element_signal,
    input wire logic                    network_enable,
    input wire logic                    network_clock,
    input wire logic                    pll_reference_clock
);
    // ****************************************************************
    // gate and register bus checks
    // ****************************************************************
    logic [6:0] off_q;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // cycles since enable dropped; room for four sync edges
    always_ff @(posedge clk) begin
        if (rst || network_enable) begin
            off_q <= 7'h00;
        end else if (off_q != 7'h7f) begin
            off_q <= off_q + 7'h01;
        end
    end

    chk_gate_off: assert property (off_q > 7'h28 |-> !network_clock)
        else $error("clock on while disabled");
    chk_src_behind: assert property (network_clock |-> |{dedicated_clock_pin,
        pll_counter_output, dual_purpose_clock_pin, fabric_logic_element_signal})
        else $error("clock with no source");
    chk_ref_pin: assert property ((pll_reference_clock == dedicated_clock_pin[0])
        || (pll_reference_clock == dedicated_clock_pin[1]))
        else $error("bad pll reference");
    chk_bresp_hold: assert property (axi_rsp.bvalid && !axi_req.bready
        |=> axi_rsp.bvalid && $stable(axi_rsp.bresp)) else $error("bvalid dropped");
    chk_rdata_hold: assert property (axi_rsp.rvalid && !axi_req.rready
        |=> axi_rsp.rvalid && $stable(axi_rsp.rdata)) else $error("rvalid dropped");
    chk_write_answer: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid
        && axi_rsp.wready |-> ##[1:2] axi_rsp.bvalid) else $error("no bvalid");
    chk_read_answer: assert property (axi_req.arvalid && axi_rsp.arready
        |=> axi_rsp.rvalid) else $error("no rvalid");
    chk_ar_blocked: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
        else $error("ar taken while busy");
    chk_aw_blocked: assert property (axi_rsp.bvalid |-> !axi_rsp.awready)
        else $error("aw taken while busy");
    chk_bad_addr: assert property (axi_req.arvalid && axi_rsp.arready
        && axi_req.araddr[31:8] != 24'h000000 |=> axi_rsp.rresp == RESP_SLVERR
        && axi_rsp.rdata == 32'h0000_0000) else $error("bad read taken");

    cov_gated: cover property (off_q == 7'h30);
    cov_slverr: cover property (axi_rsp.bvalid && axi_rsp.bresp == RESP_SLVERR);
    cov_running: cover property (network_enable && network_clock);
endmodule

bind gcsg_top gcsg_top_checker gcsg_top_checker_inst (.clk, .rst, .axi_req, .axi_rsp,
    .dedicated_clock_pin, .pll_counter_output, .dual_purpose_clock_pin,
    .fabric_logic_element_signal, .network_enable, .network_clock, .pll_reference_clock);

// *** tb/gcsg_fabric_model.sv ***
`timescale 1ns/100ps

module gcsg_fabric_model (
    output logic [5:0] src
);
    // ****************************************************************
    // source clocks: pins, counters, dual-purpose pin, fabric
    // ****************************************************************
    // unrelated half periods expose a wrong pick
    for (genvar g = 0; g < 6; g++) begin : g_src
        initial begin
            src[g] = 1'b0;
            forever #(13.3 + 3.1 * g) src[g] = ~src[g];
        end
    end
endmodule

// *** tb/global_clock_select_gate_tb_top.sv ***
`timescale 1ns/100ps

module global_clock_select_gate_tb_top;
    import gcsg_pkg::*;
    // ****************************************************************
    // bench
    // ****************************************************************
    typedef struct packed {
        logic [1:0] sel;
        logic       en;
        logic       hi;
    } gcsg_row_t;
    localparam gcsg_row_t ROWS [6] = '{'{2'h0, 1'b1, 1'b1}, '{2'h1, 1'b1, 1'b1},
        '{2'h2, 1'b1, 1'b1}, '{2'h3, 1'b1, 1'b1}, '{2'h0, 1'b0, 1'b0}, '{2'h2, 1'b1, 1'b1}};
    localparam logic [31:0] A_CFG = 32'(CFG_OFS), A_STAT = 32'(STAT_OFS);
    logic          clk, rst, net_en, ref_sw, net_clk, ref_clk;
    logic [1:0]    net_sel, resp;
    logic [5:0]    src;
    logic [31:0]   rd;
    gcsg_axi_req_t req;
    gcsg_axi_rsp_t rsp;
    int            bad_count = 0;
    int            n_tests = 0;

    gcsg_fabric_model gcsg_fabric_model_inst (.src(src));
    gcsg_top gcsg_top_inst (.clk(clk), .rst(rst), .axi_req(req), .axi_rsp(rsp),
        .dedicated_clock_pin(src[1:0]), .pll_counter_output(src[3:2]),
        .dual_purpose_clock_pin(src[4]), .fabric_logic_element_signal(src[5]),
        .network_source_select(net_sel), .network_enable(net_en),
        .pll_reference_switch(ref_sw), .network_clock(net_clk), .pll_reference_clock(ref_clk));

    task chk(input logic [33:0] seen, input logic [33:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // two periods of src[k]; o=1 watches the pll reference
    task watch(input int k, input logic hi, input logic o);
        repeat (2) begin
            wait (src[k] === 1'b0);
            wait (src[k] === 1'b1);
            #0.5;
            chk(34'(o ? ref_clk : net_clk), 34'(hi));
            wait (src[k] === 1'b0);
            #0.5;
            chk(34'(o ? ref_clk : net_clk), 34'h0);
        end
    endtask

    task axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        bit done;
        done = 1'b0;
        @(posedge clk);
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        for (int i = 0; i < 100 && !done; i++) begin
            @(posedge clk);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            if (req.bready && rsp.bvalid) begin
                r = rsp.bresp;
                req.bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask

    task axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        bit done;
        done = 1'b0;
        @(posedge clk);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        for (int i = 0; i < 100 && !done; i++) begin
            @(posedge clk);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            if (req.rready && rsp.rvalid) begin
                d = rsp.rdata;
                r = rsp.rresp;
                req.rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask

    // clock and watchdog
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        complete_run();
    end

    // main sequence
    initial begin
        rst = 1'b1;
        req = '0;
        net_sel = 2'h0;
        net_en = 1'b0;
        ref_sw = 1'b0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        axi_rd(A_CFG, rd, resp);
        chk({resp, rd}, {RESP_OKAY, CFG_RESET});
        axi_rd(A_STAT, rd, resp);
        chk({resp, 27'h0, rd[20:16]}, {RESP_OKAY, 27'h0, BLOCKS_SMALL});
        $display("test reset done");
        // enable low across each select change: no runt pulses
        foreach (ROWS[i]) begin
            @(posedge clk);
            net_en <= 1'b0;
            repeat (4) @(posedge clk);
            net_sel <= ROWS[i].sel;
            repeat (30) @(posedge clk);
            net_en <= ROWS[i].en;
            repeat (30) @(posedge clk);
            watch(int'(ROWS[i].sel), ROWS[i].hi, 1'b0);
        end
        $display("test rows done");
        axi_wr(A_CFG, 32'h0000_0011, resp);
        watch(4, 1'b1, 1'b0);
        axi_wr(A_CFG, 32'h0000_0012, resp);
        watch(5, 1'b1, 1'b0);
        axi_wr(A_CFG, 32'h0000_0000, resp);
        repeat (30) @(posedge clk);
        watch(0, 1'b0, 1'b0);
        $display("test static done");
        axi_wr(A_CFG, 32'h0000_0014, resp);
        watch(1, 1'b1, 1'b1);
        axi_wr(A_CFG, 32'h0000_0018, resp);
        watch(0, 1'b1, 1'b1);
        @(posedge clk);
        ref_sw <= 1'b1;
        repeat (4) @(posedge clk);
        watch(1, 1'b1, 1'b1);
        $display("test reference done");
        axi_wr(A_CFG, 32'h0000_0110, resp);
        axi_rd(A_STAT, rd, resp);
        chk({resp, 27'h0, rd[20:16]}, {RESP_OKAY, 27'h0, BLOCKS_LARGE});
        axi_rd(32'h0000_0100, rd, resp);
        chk({resp, rd}, {RESP_SLVERR, 32'h0});
        axi_wr(A_STAT, 32'h0000_0001, resp);
        chk(34'(resp), 34'(RESP_SLVERR));
        // lock holds the static pick until reset
        axi_wr(A_CFG, 32'h0000_0030, resp);
        axi_wr(A_CFG, 32'h0000_0011, resp);
        chk(34'(resp), 34'(RESP_SLVERR));
        axi_rd(A_CFG, rd, resp);
        chk({resp, rd}, {RESP_OKAY, 32'h0000_0030});
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        axi_rd(A_CFG, rd, resp);
        chk({resp, rd}, {RESP_OKAY, CFG_RESET});
        $display("test refusals done");
        complete_run();
    end
endmodule
